//--- hw/tgas_buf.sv
package tgas_pkg;
    // register byte offsets
    localparam logic [7:0] TGAS_OFF_CTRL   = 8'h00;
    localparam logic [7:0] TGAS_OFF_STATUS = 8'h04;
    localparam logic [7:0] TGAS_OFF_RUN    = 8'h08;
    localparam logic [7:0] TGAS_OFF_OFF    = 8'h0C;
    localparam logic [7:0] TGAS_OFF_CUR    = 8'h10;
    localparam logic [7:0] TGAS_OFF_END    = 8'h14;
    localparam logic [7:0] TGAS_OFF_COUNT  = 8'h18;
    // control and status bit positions
    localparam int TGAS_CTRL_START  = 0;
    localparam int TGAS_CTRL_STOP   = 1;
    localparam int TGAS_CTRL_NEGPOL = 2;
    localparam int TGAS_STS_RUN     = 0;
    localparam int TGAS_STS_ONPH    = 1;
    localparam int TGAS_STS_DONE    = 2;
    localparam int TGAS_STS_GATE    = 3;
    // reset values
    localparam logic [31:0] TGAS_RST_RUN = 32'h0000_0001;
    localparam logic [31:0] TGAS_RST_OFF = 32'h0000_0001;
    localparam logic [31:0] TGAS_RST_END = 32'h0000_0000;
    // bus answers
    localparam logic [1:0] TGAS_RESP_OKAY   = 2'h0;
    localparam logic [1:0] TGAS_RESP_SLVERR = 2'h2;
    // timing
    localparam int TGAS_CLK_PERIOD_NS = 25;
    localparam int TGAS_US_NS         = 1000;
    localparam int TGAS_CYC_PER_US    = TGAS_US_NS / TGAS_CLK_PERIOD_NS;
    localparam int TGAS_MIN_OFF_NS    = 200;
    localparam int TGAS_MIN_OFF_CYC   = TGAS_MIN_OFF_NS / TGAS_CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        TGAS_IDLE = 4'b0001,
        TGAS_ON   = 4'b0010,
        TGAS_CAPT = 4'b0100,
        TGAS_OFF  = 4'b1000
    } tgas_state_t;

    // one stored record: address and counter snapshot
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
    } tgas_rec_t;
endpackage : tgas_pkg

module tgas_buf
    import tgas_pkg::*;
#(
    parameter int W = 64
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    typedef struct packed {
        logic [1:0]   cnt;
        logic [W-1:0] slot0;
        logic [W-1:0] slot1;
        logic         in_rdy;
        logic         out_vld;
    } tgas_buf_st_t;

    tgas_buf_st_t q;
    tgas_buf_st_t n;
    logic         push;
    logic         pop;

    // two-entry queue, slot0 is always the head
    always_comb begin
        n    = q;
        push = in_valid && q.in_rdy;
        pop  = q.out_vld && out_ready;
        case (q.cnt)
            2'd0: begin
                if (push) begin
                    n.slot0 = in_data;
                    n.cnt   = 2'd1;
                end
            end
            2'd1: begin
                if (push && pop) begin
                    n.slot0 = in_data;
                end else if (push) begin
                    n.slot1 = in_data;
                    n.cnt   = 2'd2;
                end else if (pop) begin
                    n.cnt = 2'd0;
                end
            end
            default: begin
                if (pop) begin
                    n.slot0 = q.slot1;
                    n.cnt   = 2'd1;
                end
            end
        endcase
        n.in_rdy  = (n.cnt != 2'd2);
        n.out_vld = (n.cnt != 2'd0);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign in_ready  = q.in_rdy;
    assign out_valid = q.out_vld;
    assign out_data  = q.slot0;
endmodule : tgas_buf

//--- hw/tgas_top.sv
// Notes on behaviour
// - RUN duration register takes microseconds, 1 to 4,294,967,295.
// - reading RUN returns the stored microsecond count.
// - OFF duration register takes microseconds, 1 to 4,294,967,295.
// - OFF duration of zero gives a short gap of about 200 ns.
// - reading OFF returns the stored microsecond count.
// - internal gate alternates ON for RUN and OFF for OFF duration.
// - start command begins capture paced by internal gate with stored durations.
// - after reset capture is stopped until start arrives.
// - one record per period, from current address up to end address.
// - stop command halts capture at once, mid-period included.
// - external gate stays effective; host holds it ON for timer-only pacing.
// - external gate ON when input open, positive polarity by default.
// - stop also halts counting and every paced capture.
// - capture stops by itself once the record for the end address is taken.
module tgas_top
    import tgas_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // axi4-lite write address and data
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // external gate pin and counter side
    input  wire logic        ext_gate_pin,
    input  wire logic [31:0] snap_data,
    output logic             count_en,
    // record stream
    output logic             rec_valid,
    input  wire logic        rec_ready,
    output tgas_rec_t        rec_data
);
    typedef struct packed {
        tgas_state_t st;
        logic [5:0]  pre;
        logic [31:0] us;
        logic [31:0] run_us;
        logic [31:0] off_us;
        logic [31:0] cur_addr;
        logic [31:0] end_addr;
        logic [31:0] rec_cnt;
        logic        neg_pol;
        logic        done;
        logic        cnt_en;
        logic [1:0]  gsync;
        logic        push;
        tgas_rec_t   rec;
        logic        aw_full;
        logic        w_full;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } tgas_top_st_t;

    tgas_top_st_t q;
    tgas_top_st_t n;
    logic         buf_in_ready;
    logic         start_w;
    logic         stop_w;
    logic         gate_on;
    logic [31:0]  run_eff;

    // byte-lane merge of a write into a register
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // end of a microsecond-timed phase
    function automatic logic phase_end(input logic [5:0] pre, input logic [31:0] us,
                                       input logic [31:0] len);
        return (pre == 6'(TGAS_CYC_PER_US - 1)) && (us == len - 32'h0000_0001);
    endfunction : phase_end

    // whole next state: bus slave, gate sync and sequencer
    always_comb begin
        n       = q;
        start_w = 1'b0;
        stop_w  = 1'b0;
        run_eff = (q.run_us == 32'h0000_0000) ? 32'h0000_0001 : q.run_us;
        gate_on = q.gsync[1] ^ q.neg_pol;
        n.gsync = {q.gsync[0], ext_gate_pin};

        // write channels taken in either order
        if (s_axi_awvalid && q.awready) begin
            n.aw_full = 1'b1;
            n.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            n.w_full = 1'b1;
            n.wdata  = s_axi_wdata;
            n.wstrb  = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (q.aw_full && q.w_full && !q.bvalid) begin
            n.aw_full = 1'b0;
            n.w_full  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = TGAS_RESP_OKAY;
            case ({q.awaddr[7:2], 2'b00})
                TGAS_OFF_CTRL: begin
                    if (q.wstrb[0]) begin
                        start_w   = q.wdata[TGAS_CTRL_START];
                        stop_w    = q.wdata[TGAS_CTRL_STOP];
                        n.neg_pol = q.wdata[TGAS_CTRL_NEGPOL];
                    end
                end
                TGAS_OFF_STATUS: ;
                TGAS_OFF_COUNT: ;
                TGAS_OFF_RUN: n.run_us = merge(q.run_us, q.wdata, q.wstrb);
                TGAS_OFF_OFF: n.off_us = merge(q.off_us, q.wdata, q.wstrb);
                TGAS_OFF_CUR: begin
                    if (q.st == TGAS_IDLE) begin
                        n.cur_addr = merge(q.cur_addr, q.wdata, q.wstrb);
                    end
                end
                TGAS_OFF_END: n.end_addr = merge(q.end_addr, q.wdata, q.wstrb);
                default: n.bresp = TGAS_RESP_SLVERR;
            endcase
        end
        n.awready = !n.aw_full;
        n.wready  = !n.w_full;

        // read channel, answer one cycle after the address
        if (q.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready) begin
            n.rvalid = 1'b1;
            n.rresp  = TGAS_RESP_OKAY;
            n.rdata  = 32'h0000_0000;
            case ({s_axi_araddr[7:2], 2'b00})
                TGAS_OFF_CTRL: n.rdata[TGAS_CTRL_NEGPOL] = q.neg_pol;
                TGAS_OFF_STATUS: begin
                    n.rdata[TGAS_STS_RUN]  = (q.st != TGAS_IDLE);
                    n.rdata[TGAS_STS_ONPH] = (q.st == TGAS_ON);
                    n.rdata[TGAS_STS_DONE] = q.done;
                    n.rdata[TGAS_STS_GATE] = gate_on;
                end
                TGAS_OFF_RUN:   n.rdata = q.run_us;
                TGAS_OFF_OFF:   n.rdata = q.off_us;
                TGAS_OFF_CUR:   n.rdata = q.cur_addr;
                TGAS_OFF_END:   n.rdata = q.end_addr;
                TGAS_OFF_COUNT: n.rdata = q.rec_cnt;
                default:        n.rresp = TGAS_RESP_SLVERR;
            endcase
        end
        n.arready = !n.rvalid;

        // sequencer
        case (q.st)
            TGAS_IDLE: begin
                if (start_w && !stop_w) begin
                    n.rec_cnt = 32'h0000_0000;
                    n.pre     = 6'h00;
                    n.us      = 32'h0000_0000;
                    if (q.cur_addr <= q.end_addr) begin
                        n.st   = TGAS_ON;
                        n.done = 1'b0;
                    end else begin
                        n.done = 1'b1;
                    end
                end
            end
            TGAS_ON: begin
                n.pre = q.pre + 6'h01;
                if (q.pre == 6'(TGAS_CYC_PER_US - 1)) begin
                    n.pre = 6'h00;
                    n.us  = q.us + 32'h0000_0001;
                end
                if (phase_end(q.pre, q.us, run_eff)) begin
                    n.st   = TGAS_CAPT;
                    n.push = 1'b1;
                    n.rec  = '{addr: q.cur_addr, data: snap_data};
                end
            end
            TGAS_CAPT: begin
                if (q.push && buf_in_ready) begin
                    n.push     = 1'b0;
                    n.rec_cnt  = q.rec_cnt + 32'h0000_0001;
                    n.cur_addr = q.cur_addr + 32'h0000_0001;
                    n.pre      = 6'h00;
                    n.us       = 32'h0000_0000;
                    if (q.cur_addr == q.end_addr) begin
                        n.st   = TGAS_IDLE;
                        n.done = 1'b1;
                    end else begin
                        n.st = TGAS_OFF;
                    end
                end
            end
            TGAS_OFF: begin
                n.pre = q.pre + 6'h01;
                if (q.off_us == 32'h0000_0000) begin
                    if (q.pre == 6'(TGAS_MIN_OFF_CYC - 1)) begin
                        n.st  = TGAS_ON;
                        n.pre = 6'h00;
                    end
                end else begin
                    if (q.pre == 6'(TGAS_CYC_PER_US - 1)) begin
                        n.pre = 6'h00;
                        n.us  = q.us + 32'h0000_0001;
                    end
                    if (phase_end(q.pre, q.us, q.off_us)) begin
                        n.st = TGAS_ON;
                        n.us = 32'h0000_0000;
                    end
                end
            end
            default: n.st = TGAS_IDLE;
        endcase
        if (stop_w) begin
            n.st   = TGAS_IDLE;
            n.push = 1'b0;
        end
        n.cnt_en = (n.st == TGAS_ON) && gate_on;
    end

    // state register, comes up stopped
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q        <= '0;
            q.st     <= TGAS_IDLE;
            q.run_us <= TGAS_RST_RUN;
            q.off_us <= TGAS_RST_OFF;
            q.end_addr <= TGAS_RST_END;
        end else begin
            q <= n;
        end
    end

    // record buffer between sequencer and receiver
    tgas_buf #(
        .W($bits(tgas_rec_t))
    ) u_buf (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_valid  (q.push),
        .in_ready  (buf_in_ready),
        .in_data   (q.rec),
        .out_valid (rec_valid),
        .out_ready (rec_ready),
        .out_data  (rec_data)
    );

    // outputs from state flops
    assign s_axi_awready = q.awready;
    assign s_axi_wready  = q.wready;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;
    assign count_en      = q.cnt_en;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic [39:0] on_len;
    always_ff @(posedge ref_clk) begin
        if (rst || q.st != TGAS_ON) begin
            on_len <= 40'h00_0000_0000;
        end else begin
            on_len <= on_len + 40'h00_0000_0001;
        end
    end

    sequence s_enter_off_zero;
        q.st != TGAS_OFF ##1 q.st == TGAS_OFF && q.off_us == 32'h0000_0000;
    endsequence
    sequence s_short_gap;
        (q.st == TGAS_OFF)[*8] ##1 q.st == TGAS_ON;
    endsequence

    property p_reset_stopped;
        @(posedge ref_clk) disable iff (1'b0) rst |=> q.st == TGAS_IDLE && !count_en;
    endproperty
    a_reset_stopped: assert property (p_reset_stopped) else $error("not stopped after reset");

    property p_stop_halts;
        stop_w |=> q.st == TGAS_IDLE && !count_en && !q.push;
    endproperty
    a_stop_halts: assert property (p_stop_halts) else $error("stop did not halt");

    property p_start_runs;
        q.st == TGAS_IDLE && start_w && !stop_w && q.cur_addr <= q.end_addr
            |=> q.st == TGAS_ON ##1 q.st == TGAS_ON || stop_w;
    endproperty
    a_start_runs: assert property (p_start_runs) else $error("start did not enter ON");

    property p_on_length;
        q.st == TGAS_ON ##1 q.st == TGAS_CAPT
            |-> $past(on_len) + 40'h00_0000_0001 == 40'(run_eff) * 40'(TGAS_CYC_PER_US);
    endproperty
    a_on_length: assert property (p_on_length) else $error("ON phase length wrong");

    property p_short_gap;
        s_enter_off_zero |-> s_short_gap or (##[0:7] stop_w);
    endproperty
    a_short_gap: assert property (p_short_gap) else $error("zero OFF gap wrong");

    property p_record_step;
        q.push && buf_in_ready && q.st == TGAS_CAPT && !stop_w
            |=> q.cur_addr == $past(q.cur_addr) + 32'h0000_0001
                && q.rec_cnt == $past(q.rec_cnt) + 32'h0000_0001;
    endproperty
    a_record_step: assert property (p_record_step) else $error("address did not step");

    property p_auto_stop;
        q.push && buf_in_ready && q.st == TGAS_CAPT && q.cur_addr == q.end_addr
            |=> q.st == TGAS_IDLE && q.done;
    endproperty
    a_auto_stop: assert property (p_auto_stop) else $error("no stop at end address");

    property p_capture_at_on_end;
        q.st == TGAS_ON ##1 q.st == TGAS_CAPT |-> q.push && q.rec.addr == q.cur_addr;
    endproperty
    a_capture_at_on_end: assert property (p_capture_at_on_end) else $error("no capture");

    property p_count_gated;
        count_en |-> q.st == TGAS_ON && $past(q.gsync[1] ^ q.neg_pol);
    endproperty
    a_count_gated: assert property (p_count_gated) else $error("count without gate");

    property p_run_read;
        s_axi_arvalid && q.arready && s_axi_araddr == TGAS_OFF_RUN
            |=> s_axi_rvalid && s_axi_rdata == $past(q.run_us);
    endproperty
    a_run_read: assert property (p_run_read) else $error("RUN readback wrong");
endmodule : tgas_top

//--- sim/tgas_far_model.sv
module tgas_far_model
    import tgas_pkg::*;
(
    // clock and reset
    input  wire logic      ref_clk,
    input  wire logic      rst,
    // counter side
    input  wire logic      count_en,
    output logic [31:0]    snap_data,
    // record sink
    input  wire logic      hold,
    input  wire logic      rec_valid,
    output logic           rec_ready,
    input  wire tgas_rec_t rec_data,
    // last seen phase lengths
    output int             on_len,
    output int             off_len
);
    timeunit 1ns;
    timeprecision 100ps;

    tgas_rec_t recs[$];
    int        run_len;
    logic      en_q;

    // sink stalls only on request
    assign rec_ready = !hold;

    // snapshot steps once per counting phase, lengths of both phases
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            snap_data <= 32'hA5A5_0000;
            en_q      <= 1'b0;
            run_len   <= 1;
            on_len    <= 0;
            off_len   <= 0;
        end else begin
            en_q <= count_en;
            if (count_en !== en_q) begin
                if (en_q) on_len <= run_len;
                else off_len <= run_len;
                run_len <= 1;
            end else begin
                run_len <= run_len + 1;
            end
            if (count_en && !en_q) snap_data <= snap_data + 32'h0000_0001;
            if (rec_valid && rec_ready) recs.push_back(rec_data);
        end
    end
endmodule : tgas_far_model

//--- sim/tb_timed_gate_acquisition_sequencer.sv
module tb_timed_gate_acquisition_sequencer
    import tgas_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        ref_clk, rst, ext_gate_pin, count_en, hold;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, snap_data;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [31:0] d;
    logic        rec_valid, rec_ready;
    tgas_rec_t   rec_data;
    int          on_len, off_len, failures, checks, n0, n1, k;
    logic [31:0] vals [2] = '{32'hFFFF_FFFF, 32'h0000_0001};

    tgas_top dut (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .ext_gate_pin(ext_gate_pin), .snap_data(snap_data),
        .count_en(count_en), .rec_valid(rec_valid), .rec_ready(rec_ready),
        .rec_data(rec_data));

    tgas_far_model far (.ref_clk(ref_clk), .rst(rst), .count_en(count_en),
        .snap_data(snap_data), .hold(hold), .rec_valid(rec_valid), .rec_ready(rec_ready),
        .rec_data(rec_data), .on_len(on_len), .off_len(off_len));

    // clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic summarize();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        logic aw_left;
        logic w_left;
        aw_left = 1'b1;
        w_left  = 1'b1;
        @(posedge ref_clk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= v;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (aw_left || w_left) begin
            @(posedge ref_clk);
            if (aw_left && s_axi_awready === 1'b1) begin
                s_axi_awvalid <= 1'b0;
                aw_left = 1'b0;
            end
            if (w_left && s_axi_wready === 1'b1) begin
                s_axi_wvalid <= 1'b0;
                w_left = 1'b0;
            end
        end
        do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        @(posedge ref_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
        v    = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic wrc(input logic [7:0] a, input logic [31:0] v);
        logic [1:0] resp;
        wr(a, v, resp);
        chk("write answer", TGAS_RESP_OKAY, resp);
    endtask : wrc

    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] mask,
                       input logic [31:0] exp);
        logic [31:0] v;
        logic [1:0]  resp;
        rd(a, v, resp);
        chk(what, exp, v & mask);
    endtask : rdc

    task automatic wait_recs(input int n);
        for (int i = 0; i < 2000 && far.recs.size() < n; i++) @(posedge ref_clk);
        chk("records arrived", 1'b1, far.recs.size() >= n);
    endtask : wait_recs

    // watchdog
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        summarize();
    end

    // main sequence
    initial begin
        failures = 0;
        checks = 0;
        rst = 1'b1;
        ext_gate_pin = 1'b1;
        hold = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        // values after reset
        rdc("run reset", TGAS_OFF_RUN, 32'hFFFF_FFFF, TGAS_RST_RUN);
        rdc("off reset", TGAS_OFF_OFF, 32'hFFFF_FFFF, TGAS_RST_OFF);
        rdc("end reset", TGAS_OFF_END, 32'hFFFF_FFFF, TGAS_RST_END);
        rdc("status reset", TGAS_OFF_STATUS, 32'h0000_000F, 32'h0000_0008);
        chk("count_en idle", 1'b0, count_en);
        // durations at both ends of the range
        foreach (vals[i]) begin
            wrc(TGAS_OFF_RUN, vals[i]);
            rdc("run readback", TGAS_OFF_RUN, 32'hFFFF_FFFF, vals[i]);
            wrc(TGAS_OFF_OFF, vals[i]);
            rdc("off readback", TGAS_OFF_OFF, 32'hFFFF_FFFF, vals[i]);
        end
        // unmapped place
        wr(8'h1C, 32'h0000_0001, r);
        chk("unmapped write", TGAS_RESP_SLVERR, r);
        rd(8'h1C, d, r);
        chk("unmapped read", {TGAS_RESP_SLVERR, 32'h0000_0000}, {r, d});
        // three records while the sink stalls, then drained in order
        wrc(TGAS_OFF_OFF, 32'h0000_0000);
        rdc("off zero", TGAS_OFF_OFF, 32'hFFFF_FFFF, 32'h0000_0000);
        wrc(TGAS_OFF_CUR, 32'h0000_0004);
        wrc(TGAS_OFF_END, 32'h0000_0006);
        hold <= 1'b1;
        wrc(TGAS_OFF_CTRL, 32'h0000_0001);
        repeat (200) @(posedge ref_clk);
        chk("records while stalled", 0, far.recs.size());
        rdc("running while stalled", TGAS_OFF_STATUS, 32'h0000_0001, 32'h0000_0001);
        hold <= 1'b0;
        wait_recs(3);
        chk("record count", 3, far.recs.size());
        for (k = 0; k < 3 && k < far.recs.size(); k++) begin
            chk("record", {32'h0000_0004 + k, 32'hA5A5_0001 + k}, far.recs[k]);
        end
        chk("on phase length", 40, on_len);
        rdc("status done", TGAS_OFF_STATUS, 32'h0000_0005, 32'h0000_0004);
        rdc("cur after end", TGAS_OFF_CUR, 32'hFFFF_FFFF, 32'h0000_0007);
        rdc("record total", TGAS_OFF_COUNT, 32'hFFFF_FFFF, 32'h0000_0003);
        // stop in the middle of an on phase
        wrc(TGAS_OFF_CUR, 32'h0000_0000);
        wrc(TGAS_OFF_END, 32'h0000_0064);
        n0 = far.recs.size();
        wrc(TGAS_OFF_CTRL, 32'h0000_0001);
        wait_recs(n0 + 2);
        repeat (14) @(posedge ref_clk);
        chk("short off gap", 1'b1, off_len >= 9 && off_len <= 11);
        chk("counting in on phase", 1'b1, count_en);
        ext_gate_pin <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk("count_en gate off", 1'b0, count_en);
        ext_gate_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk("count_en gate on", 1'b1, count_en);
        wrc(TGAS_OFF_CTRL, 32'h0000_0002);
        repeat (2) @(posedge ref_clk);
        chk("count_en after stop", 1'b0, count_en);
        rdc("stopped", TGAS_OFF_STATUS, 32'h0000_0001, 32'h0000_0000);
        n1 = far.recs.size();
        repeat (200) @(posedge ref_clk);
        chk("no record after stop", n1, far.recs.size());
        // gate polarity
        ext_gate_pin <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rdc("gate low positive", TGAS_OFF_STATUS, 32'h0000_0008, 32'h0000_0000);
        wrc(TGAS_OFF_CTRL, 32'h0000_0004);
        rdc("gate low negative", TGAS_OFF_STATUS, 32'h0000_0008, 32'h0000_0008);
        summarize();
    end
endmodule : tb_timed_gate_acquisition_sequencer
